// ===== tct_pkg.sv
// Package of constants and types for the thermal clock throttle block
package tct_pkg;
   // Bit positions inside the thermal control word
   localparam int unsigned CTL_WIDTH       = 5;
   localparam int unsigned CTL_ODM_EN_BIT  = 4;
   localparam int unsigned CTL_DUTY_LSB    = 1;
   localparam int unsigned CTL_DUTY_MSB    = 3;
   localparam logic [4:0]  CTL_RESET       = 5'h00;
   // Modulation period is eight slots; each slot is a number of core clocks
   localparam int unsigned SLOT_BITS       = 3;
   localparam logic [2:0]  SLOT_LAST       = 3'h7;
   localparam int unsigned SLOT_CYC_BITS   = 4;
   localparam logic [3:0]  SLOT_CYC_LAST   = 4'hf;
   // Fixed automatic duty: four of eight slots on (50%)
   localparam logic [2:0]  AUTO_DUTY       = 3'h4;
   // Hysteresis: samples of the cool flag needed to release the trip
   localparam int unsigned HYST_BITS       = 5;
   localparam logic [4:0]  HYST_LAST       = 5'h1f;

   // Throttle state
   typedef enum logic [1:0] {
      TCT_IDLE = 2'b00,
      TCT_AUTO = 2'b01,
      TCT_ODM  = 2'b10
   } tct_state_t;
endpackage

// ===== tct_sync_if.sv
// Interface carrying a synchronised flag between block modules
`timescale 1ns/100ps
`default_nettype none
interface tct_sync_if;
   logic raw;
   logic synced;
   modport src (output raw, input synced);
   modport snk (input raw, output synced);
endinterface
`default_nettype wire

// ===== tct_sync2.sv
// Two-flop synchroniser for an asynchronous level
`timescale 1ns/100ps
`default_nettype none
module tct_sync2 (
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic clk_en,
   tct_sync_if.snk   sif
);
   logic meta_reg;
   logic sync_reg;

   // First flop feeds only the second
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else if (clk_en) begin
         meta_reg <= sif.raw;
         sync_reg <= meta_reg;
      end
   end

   assign sif.synced = sync_reg;
endmodule
`default_nettype wire

// ===== tct_top.sv
// Thermal clock throttle: trip detection, clock modulation, hot and trip pins
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Automatic throttling starts only at fixed trip
// - Keep snooping; latch interrupts, serve while running
// - Throttle by stopping clocks, never changing frequency
// - Automatic mode overrides on-demand when hot
// - Automatic mode uses fixed 50% duty
// - Modulation period counted in core clocks
// - Stop throttling after hysteresis once cool
// - On-demand bit 4 throttles immediately
// - On-demand duty from bits 3:1
// - Hot indicator low while above trip
// - Hot indicator not newly asserted when asleep
// - Asserted hot stays until wake and cool
// - Catastrophic trip shuts core, asserts trip pin
// - Trip pin independent of activity, no bus
module tct_top (
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       clk_en,
   input  wire logic       auto_mode_en,
   input  wire logic [4:0] thermal_ctl,
   input  wire logic       temp_over_trip,
   input  wire logic       temp_catastrophic,
   input  wire logic       low_power_state,
   input  wire logic       bus_snoop_req,
   input  wire logic       irq_req,
   input  wire logic       irq_taken,
   output logic            core_clk_run,
   output logic            throttle_active,
   output logic            auto_hot_active,
   output logic            hot_indicator_n,
   output logic            catastrophic_trip_n,
   output logic            core_shutdown,
   output logic            snoop_ack,
   output logic            irq_pending,
   output logic            irq_service
);
   tct_sync_if hot_if ();
   tct_sync_if cat_if ();

   assign hot_if.raw = temp_over_trip;
   assign cat_if.raw = temp_catastrophic;

   tct_sync2 u_sync_hot (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .sif     (hot_if.snk)
   );

   tct_sync2 u_sync_cat (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .sif     (cat_if.snk)
   );

   logic                               hot_s;
   logic                               cat_s;
   assign hot_s = hot_if.synced;
   assign cat_s = cat_if.synced;

   tct_pkg::tct_state_t                state_reg;
   tct_pkg::tct_state_t                state_next;
   logic                               trip_reg;
   logic                               trip_next;
   logic [tct_pkg::HYST_BITS-1:0]      hyst_reg;
   logic [tct_pkg::HYST_BITS-1:0]      hyst_next;
   logic [tct_pkg::SLOT_CYC_BITS-1:0]  cyc_reg;
   logic [tct_pkg::SLOT_BITS-1:0]      slot_reg;
   logic                               run_reg;
   logic                               hot_n_reg;
   logic                               cat_n_reg;
   logic                               shut_reg;
   logic                               irq_pend_reg;
   logic                               irq_srv_reg;
   logic                               snoop_reg;

   // Control word fields
   logic                               odm_en;
   logic [2:0]                         odm_duty;
   assign odm_en   = thermal_ctl[tct_pkg::CTL_ODM_EN_BIT];
   assign odm_duty = thermal_ctl[tct_pkg::CTL_DUTY_MSB:tct_pkg::CTL_DUTY_LSB];

   // hysteresis, release only after a run of cool samples
   logic                               hyst_done;
   assign hyst_done = (hyst_reg == tct_pkg::HYST_LAST);
   always_comb begin
      trip_next = trip_reg;
      hyst_next = hyst_reg;
      if (hot_s) begin
         // trip is a fixed hardware point, not visible to software
         trip_next = 1'b1;
         hyst_next = '0;
      end else if (trip_reg) begin
         if (hyst_done) begin
            trip_next = 1'b0;
            hyst_next = '0;
         end else begin
            hyst_next = hyst_reg + 5'h01;
         end
      end
   end

   // automatic mode only acts when firmware enabled it
   logic                               auto_want;
   assign auto_want = auto_mode_en && trip_reg;

   // automatic wins over on-demand when both apply
   always_comb begin
      if (auto_want) begin
         state_next = tct_pkg::TCT_AUTO;
      end else if (odm_en) begin
         state_next = tct_pkg::TCT_ODM;
      end else begin
         state_next = tct_pkg::TCT_IDLE;
      end
   end

   // Duty in eighths for the current state
   logic [2:0]                         duty_sel;
   logic                               duty_ok;
   always_comb begin
      case (state_reg)
         tct_pkg::TCT_AUTO: duty_sel = tct_pkg::AUTO_DUTY;
         tct_pkg::TCT_ODM:  duty_sel = odm_duty;
         default:           duty_sel = tct_pkg::SLOT_LAST;
      endcase
   end
   // zero duty is reserved; treated as no throttling
   assign duty_ok = (state_reg != tct_pkg::TCT_IDLE) && (duty_sel != 3'h0);

   // slots count core clocks, so period shrinks as clock rises
   logic                               slot_end;
   logic                               period_end;
   assign slot_end   = (cyc_reg == tct_pkg::SLOT_CYC_LAST);
   assign period_end = slot_end && (slot_reg == tct_pkg::SLOT_LAST);

   // clocks on for slots below duty, off for the rest
   logic                               run_next;
   assign run_next = cat_n_reg && !shut_reg && !cat_s &&
                     (!duty_ok || (slot_reg < duty_sel));

   // State, hysteresis and modulation counters
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= tct_pkg::TCT_IDLE;
         trip_reg  <= 1'b0;
         hyst_reg  <= '0;
      end else if (clk_en) begin
         state_reg <= state_next;
         trip_reg  <= trip_next;
         hyst_reg  <= hyst_next;
      end
   end

   // Period restarts at a mode change so a new duty starts clean
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cyc_reg  <= '0;
         slot_reg <= '0;
      end else if (clk_en) begin
         if (state_next != state_reg) begin
            cyc_reg  <= '0;
            slot_reg <= '0;
         end else begin
            cyc_reg <= cyc_reg + 4'h1;
            if (slot_end) begin
               slot_reg <= slot_reg + 3'h1;
            end
         end
      end
   end

   // Clock gate and status outputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         run_reg <= 1'b1;
      end else if (clk_en) begin
         run_reg <= run_next;
      end
   end

   // no new assertion while clocks stopped in low power
   // an assertion already made holds through low power
   logic                               hot_n_next;
   assign hot_n_next = low_power_state ? hot_n_reg : !hot_s;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hot_n_reg <= 1'b1;
      end else if (clk_en) begin
         hot_n_reg <= hot_n_next;
      end
   end

   // catastrophic trip latches until reset and shuts core down
   // pure flag path, no bus cycle, ignores core activity
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cat_n_reg <= 1'b1;
         shut_reg  <= 1'b0;
      end else if (clk_en) begin
         if (cat_s) begin
            cat_n_reg <= 1'b0;
            shut_reg  <= 1'b1;
         end
      end
   end
   // the platform then removes core supply; nothing to do here

   // snoops answered unless core shut down; interrupts held until clocks run
   logic                               irq_pend_next;
   logic                               irq_srv_next;
   assign irq_srv_next  = (irq_pend_reg || irq_req) && run_reg &&
                          !shut_reg;
   // Set wins over clear so a request in the taken cycle is kept
   assign irq_pend_next = irq_req || (irq_pend_reg && !irq_taken);
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_pend_reg <= 1'b0;
         irq_srv_reg  <= 1'b0;
         snoop_reg    <= 1'b0;
      end else if (clk_en) begin
         irq_pend_reg <= irq_pend_next;
         irq_srv_reg  <= irq_srv_next;
         snoop_reg    <= bus_snoop_req && !shut_reg;
      end
   end

   // Status mirrors; registered so outputs come from flops
   logic                               thr_reg;
   logic                               auto_reg;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         thr_reg  <= 1'b0;
         auto_reg <= 1'b0;
      end else if (clk_en) begin
         thr_reg  <= duty_ok;
         auto_reg <= (state_reg == tct_pkg::TCT_AUTO);
      end
   end

   // platform watches diode while low power hides the indicator
   assign core_clk_run        = run_reg;
   assign throttle_active     = thr_reg;
   assign auto_hot_active     = auto_reg;
   assign hot_indicator_n     = hot_n_reg;
   assign catastrophic_trip_n = cat_n_reg;
   assign core_shutdown       = shut_reg;
   assign snoop_ack           = snoop_reg;
   assign irq_pending         = irq_pend_reg;
   assign irq_service         = irq_srv_reg;
endmodule
`default_nettype wire

// ===== tct_monitor.sv
// Port checker for the thermal clock throttle top
`timescale 1ns/100ps
`default_nettype none
module tct_monitor (
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire logic       clk_en,
   input wire logic       auto_mode_en,
   input wire logic [4:0] thermal_ctl,
   input wire logic       temp_over_trip,
   input wire logic       temp_catastrophic,
   input wire logic       low_power_state,
   input wire logic       bus_snoop_req,
   input wire logic       irq_req,
   input wire logic       core_clk_run,
   input wire logic       throttle_active,
   input wire logic       auto_hot_active,
   input wire logic       hot_indicator_n,
   input wire logic       catastrophic_trip_n,
   input wire logic       core_shutdown,
   input wire logic       snoop_ack,
   input wire logic       irq_pending
);
   logic [7:0] off_cnt_reg;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Length of the gated-off run; saturates so it never wraps
   always_ff @(posedge clk_sys) begin
      if (reset || core_clk_run) begin
         off_cnt_reg <= 8'h00;
      end else if (clk_en && off_cnt_reg != 8'hff) begin
         off_cnt_reg <= off_cnt_reg + 8'h01;
      end
   end
   a_hot_after_trip: assert property (
      (temp_over_trip && !low_power_state && clk_en)[*4] |-> !hot_indicator_n)
      else $error("hot indicator late");
   a_hot_sleep_hold: assert property (
      low_power_state && clk_en |=> $stable(hot_indicator_n))
      else $error("hot indicator moved in sleep");
   a_trip_latch: assert property (
      (temp_catastrophic && clk_en)[*4] |-> !catastrophic_trip_n && core_shutdown)
      else $error("trip late");
   a_trip_sticky: assert property (
      !catastrophic_trip_n |=> !catastrophic_trip_n && core_shutdown)
      else $error("trip released");
   a_snoop_echo: assert property (
      clk_en && !core_shutdown ##1 !core_shutdown |-> snoop_ack == $past(bus_snoop_req))
      else $error("snoop not echoed");
   a_shutdown_quiet: assert property (
      core_shutdown && clk_en |=> !snoop_ack)
      else $error("bus activity after trip");
   a_auto_takes_over: assert property (
      (auto_mode_en && temp_over_trip && !low_power_state && clk_en)[*6]
      |-> auto_hot_active)
      else $error("automatic mode not in control");
   a_idle_runs: assert property (
      (!auto_mode_en && !thermal_ctl[4] && clk_en)[*4]
      |-> !throttle_active && (core_clk_run || core_shutdown))
      else $error("throttling while disabled");
   a_irq_latched: assert property (
      irq_req && clk_en |=> irq_pending)
      else $error("interrupt lost");
   a_off_bounded: assert property (
      !core_shutdown && !core_clk_run |-> off_cnt_reg < 8'h70)
      else $error("clock off too long");
   c_auto: cover property (auto_hot_active && !core_clk_run);
   c_odm: cover property (thermal_ctl[4] && throttle_active && !auto_hot_active);
   c_trip: cover property (!catastrophic_trip_n);
endmodule
bind tct_top tct_monitor mon (.clk_sys, .reset, .clk_en, .auto_mode_en,
   .thermal_ctl, .temp_over_trip, .temp_catastrophic, .low_power_state,
   .bus_snoop_req, .irq_req, .core_clk_run, .throttle_active,
   .auto_hot_active, .hot_indicator_n, .catastrophic_trip_n,
   .core_shutdown, .snoop_ack, .irq_pending);
`default_nettype wire

// ===== tct_platform.sv
// Platform power model: cuts core supply after a catastrophic trip
`timescale 1ns/100ps
`default_nettype none
module tct_platform #(
   parameter int CUT_DELAY = 4
) (
   input  wire logic clk_sys,
   input  wire logic catastrophic_trip_n,
   input  wire logic low_power_state,
   input  wire logic diode_over,
   output var logic  core_supply_on,
   output logic      orderly_down
);
   int cnt = 0;
   initial core_supply_on = 1'b1;
   // bounded cut; the delay sets a prompt or slow platform
   always @(posedge clk_sys) begin
      if (!catastrophic_trip_n) begin
         cnt <= cnt + 1;
      end
      if (cnt >= CUT_DELAY) begin
         core_supply_on <= 1'b0;
      end
   end
   // diode guards the die while the hot pin is blind in sleep
   assign orderly_down = low_power_state && diode_over;
endmodule
`default_nettype wire

// ===== thermal_clock_throttle_bench.sv
// Testbench of the thermal clock throttle top
`timescale 1ns/100ps
`default_nettype none
module thermal_clock_throttle_bench;
   logic       clk_sys, reset, clk_en, auto_mode_en, temp_over_trip;
   logic       temp_catastrophic, low_power_state, bus_snoop_req;
   logic       irq_req, irq_taken, diode_over, core_clk_run;
   logic       throttle_active, auto_hot_active, hot_indicator_n;
   logic       catastrophic_trip_n, core_shutdown, snoop_ack;
   logic       irq_pending, irq_service, core_supply_on, orderly_down;
   logic [4:0] thermal_ctl;
   int         mismatches = 0, compares = 0, on_cnt;
   int         seed = 32'he504;

   tct_top dut (.clk_sys, .reset, .clk_en, .auto_mode_en, .thermal_ctl,
      .temp_over_trip, .temp_catastrophic, .low_power_state,
      .bus_snoop_req, .irq_req, .irq_taken, .core_clk_run,
      .throttle_active, .auto_hot_active, .hot_indicator_n,
      .catastrophic_trip_n, .core_shutdown, .snoop_ack, .irq_pending,
      .irq_service);
   tct_platform #(.CUT_DELAY(6)) plat (.clk_sys, .catastrophic_trip_n,
      .low_power_state, .diode_over, .core_supply_on, .orderly_down);

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Random snoop traffic; its echo is judged by the checker
   always @(negedge clk_sys) begin
      bus_snoop_req <= 1'($random(seed));
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Model of clock-on cycles in one 128-cycle period, duty in eighths
   function automatic int on_model(input int duty);
      return (duty == 0) ? 128 : duty * 16;
   endfunction
   task automatic count_on();
      on_cnt = 0;
      repeat (128) begin
         @(negedge clk_sys);
         on_cnt += int'(core_clk_run === 1'b1);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      {reset, clk_en, auto_mode_en, temp_over_trip, temp_catastrophic} = 5'h18;
      {low_power_state, irq_req, irq_taken, diode_over} = 4'h0;
      thermal_ctl = 5'h00;
      cyc(20);
      reset = 1'b0;
      chk({core_clk_run, hot_indicator_n, catastrophic_trip_n}, 3'h7);
      auto_mode_en = 1'b1;
      count_on();
      chk(on_cnt, on_model(0));
      $display("test cool done");
      for (int d = 0; d < 8; d++) begin
         thermal_ctl = {1'b1, 3'(d), 1'($random(seed))};
         cyc(130);
         count_on();
         chk(on_cnt, on_model(d));
         chk(throttle_active, d != 0);
      end
      $display("test duty done");
      thermal_ctl = 5'h12;
      temp_over_trip = 1'b1;
      cyc(4);
      chk(hot_indicator_n, 1'b0);
      cyc(130);
      count_on();
      chk(on_cnt, on_model(4));
      chk(auto_hot_active, 1'b1);
      temp_over_trip = 1'b0;
      cyc(10);
      chk(auto_hot_active, 1'b1);
      thermal_ctl = 5'h00;
      cyc(60);
      chk(throttle_active, 1'b0);
      $display("test auto done");
      clk_en = 1'b0;
      temp_over_trip = 1'b1;
      cyc(8);
      chk(hot_indicator_n, 1'b1);
      temp_over_trip = 1'b0;
      clk_en = 1'b1;
      {low_power_state, diode_over, temp_over_trip} = 3'h7;
      cyc(8);
      chk({hot_indicator_n, orderly_down}, 2'h3);
      low_power_state = 1'b0;
      cyc(4);
      chk(hot_indicator_n, 1'b0);
      {low_power_state, temp_over_trip} = 2'h2;
      cyc(8);
      chk(hot_indicator_n, 1'b0);
      {low_power_state, diode_over} = 2'h0;
      cyc(4);
      chk(hot_indicator_n, 1'b1);
      cyc(60);
      $display("test sleep done");
      irq_req = 1'b1;
      cyc(1);
      irq_req = 1'b0;
      cyc(2);
      chk(irq_pending, 1'b1);
      chk(irq_service, 1'b1);
      irq_taken = 1'b1;
      cyc(1);
      irq_taken = 1'b0;
      cyc(2);
      chk(irq_pending, 1'b0);
      chk(irq_service, 1'b0);
      $display("test irq done");
      // Hot with automatic mode off: indicator only, no throttling
      auto_mode_en = 1'b0;
      temp_over_trip = 1'b1;
      cyc(10);
      chk(auto_hot_active, 1'b0);
      chk(throttle_active, 1'b0);
      chk(hot_indicator_n, 1'b0);
      count_on();
      chk(on_cnt, on_model(0));
      temp_over_trip = 1'b0;
      cyc(4);
      $display("test manual done");
      temp_catastrophic = 1'b1;
      cyc(4);
      temp_catastrophic = 1'b0;
      cyc(12);
      chk({catastrophic_trip_n, core_shutdown, core_supply_on}, 3'h2);
      $display("test trip done");
      complete_run();
   end
   // Watchdog well beyond the expected run length
   initial begin
      #(40 * 5000);
      mismatches++;
      complete_run();
   end
endmodule
`default_nettype wire
